// file: src/tccd_timer.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module tccd_timer
  import tccd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Timer pins
  input  wire logic          captPin,
  output logic               cmpPin,
  // DMA controller
  output tccd_dma_req_s      dmaReq,
  input  wire tccd_dma_ack_s dmaAck,
  // Interrupt
  output logic               irq
);

  logic [7:0]          ctrl;
  logic [15:0]         counter;
  logic [15:0]         capt0;
  logic [15:0]         cmp0;
  logic [7:0]          status;
  logic [7:0]          irqMask;
  logic                captPrev;
  logic                captSync;
  logic [TCCD_NCH-1:0] dmaSel;
  logic [TCCD_NCH-1:0] chReq;
  logic [TCCD_NCH-1:0] chEvt;
  logic [TCCD_NCH-1:0] chSwVal;
  logic                captEvt;
  logic                cmpHit;
  logic                wrEn;
  logic                accStart;
  logic [9:0]          regIdx;
  logic [7:0]          maskRead;
  logic [7:0]          evtSet;

  logic [7:0]          next_ctrl;
  logic [15:0]         next_counter;
  logic [15:0]         next_capt0;
  logic [15:0]         next_cmp0;
  logic [7:0]          next_status;
  logic [7:0]          next_irqMask;
  logic                next_captPrev;
  logic                next_cmpPin;
  logic                next_irq;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic                next_pslverr;

  // Capture pin comes from outside, so it is synchronised first
  tccd_sync u_captSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     (captPin),
    .dout    (captSync)
  );

  // Sub-word offsets are ignored; every register is one aligned word
  // Bus decode; writes land only on the completing edge
  assign regIdx   = paddr[11:2];
  assign accStart = psel && penable && !pready;
  assign wrEn     = psel && penable && pready && pwrite && !pslverr;

  // Edge qualification on the synchronised capture level
  always_comb begin
    if (ctrl[TCCD_CTRL_FALL]) begin
      captEvt = ctrl[TCCD_CTRL_CAPT_EN] && captPrev && !captSync;
    end else begin
      captEvt = ctrl[TCCD_CTRL_CAPT_EN] && !captPrev && captSync;
    end
  end

  // Match only while running, else a held counter would toggle every cycle
  assign cmpHit = ctrl[TCCD_CTRL_RUN] && ctrl[TCCD_CTRL_CMP_EN] && (counter == cmp0);

  // Event routing per channel
  assign chEvt[TCCD_CH_CAPT]   = captEvt;
  assign chEvt[TCCD_CH_CMP]    = cmpHit;
  assign chSwVal[TCCD_CH_CAPT] = pwdata[TCCD_MASK_CP_DMA];
  assign chSwVal[TCCD_CH_CMP]  = pwdata[TCCD_MASK_CM_DMA];

  // One select bit and request tracker per channel
  for (genvar g = 0; g < TCCD_NCH; g++) begin : g_chan
    tccd_dma_chan u_chan (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .swWr    (wrEn && (regIdx == TCCD_IDX_MASK)),
      .swVal   (chSwVal[g]),
      .evt     (chEvt[g]),
      .ack     (dmaAck.ack[g]),
      .eob     (dmaAck.eob),
      .sel     (dmaSel[g]),
      .req     (chReq[g])
    );
  end

  // A capture in DMA mode leaves no status bit; only the DMA request shows it
  // Interrupt only when the channel is not in DMA mode
  always_comb begin
    evtSet                = 8'h00;
    evtSet[TCCD_EVT_CAPT] = captEvt && !dmaSel[TCCD_CH_CAPT];
    evtSet[TCCD_EVT_CMP]  = cmpHit && !dmaSel[TCCD_CH_CMP];
  end

  // Mask register view: interrupt enables plus DMA selects
  always_comb begin
    maskRead                   = irqMask;
    maskRead[TCCD_MASK_CP_DMA] = dmaSel[TCCD_CH_CAPT];
    maskRead[TCCD_MASK_CM_DMA] = dmaSel[TCCD_CH_CMP];
  end

  // Clock enable low freezes every timer register at once
  // Counter wraps from ffff to zero and raises no flag
  // Timer state next values
  always_comb begin
    next_ctrl     = ctrl;
    next_counter  = counter;
    next_capt0    = capt0;
    next_cmp0     = cmp0;
    next_status   = status;
    next_irqMask  = irqMask;
    next_captPrev = captPrev;
    next_cmpPin   = cmpPin;
    next_irq      = irq;
    if (ce) begin
      next_captPrev = captSync;
      if (ctrl[TCCD_CTRL_RUN]) begin
        next_counter = 16'(counter + 16'h0001);
      end
      if (captEvt) begin
        next_capt0 = counter;
      end
      if (cmpHit) begin
        next_cmpPin = !cmpPin;
      end
      if (wrEn) begin
        unique case (regIdx)
          TCCD_IDX_CTRL: next_ctrl = pwdata[7:0];
          TCCD_IDX_CMP0: next_cmp0 = pwdata[15:0];
          TCCD_IDX_STAT: next_status = status & ~pwdata[7:0];
          // Only the two enables live here; the selects sit in the channels
          TCCD_IDX_MASK: begin
            next_irqMask = 8'h00;
            next_irqMask[TCCD_EVT_CAPT] = pwdata[TCCD_EVT_CAPT];
            next_irqMask[TCCD_EVT_CMP]  = pwdata[TCCD_EVT_CMP];
          end
          default: ;
        endcase
      end
      // Reload from memory wins over a software write in the same cycle
      if (dmaAck.ack[TCCD_CH_CMP]) begin
        next_cmp0 = dmaAck.wrData;
      end
      // A new event beats a one-to-clear in the same cycle
      next_status = next_status | evtSet;
      next_irq    = |(next_status & next_irqMask);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= TCCD_CTRL_RST;
      counter  <= TCCD_CNT_RST;
      capt0    <= TCCD_CAPT_RST;
      cmp0     <= TCCD_CMP_RST;
      status   <= TCCD_STAT_RST;
      irqMask  <= TCCD_IRQM_RST;
      captPrev <= TCCD_PIN_RST;
      cmpPin   <= TCCD_PIN_RST;
      irq      <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      counter  <= next_counter;
      capt0    <= next_capt0;
      cmp0     <= next_cmp0;
      status   <= next_status;
      irqMask  <= next_irqMask;
      captPrev <= next_captPrev;
      cmpPin   <= next_cmpPin;
      irq      <= next_irq;
    end
  end

  // Bus answer one cycle into the access phase, read data registered
  // Read data is taken a cycle before a write of the same transfer lands
  always_comb begin
    next_pready  = pready;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (ce) begin
      next_pready  = accStart;
      next_pslverr = 1'b0;
      if (accStart) begin
        next_prdata = 32'h0000_0000;
        unique case (regIdx)
          TCCD_IDX_CTRL:  next_prdata[7:0]  = ctrl;
          TCCD_IDX_COUNT: next_prdata[15:0] = counter;
          TCCD_IDX_CAPT0: next_prdata[15:0] = capt0;
          TCCD_IDX_CMP0:  next_prdata[15:0] = cmp0;
          TCCD_IDX_STAT:  next_prdata[7:0]  = status;
          TCCD_IDX_MASK:  next_prdata[7:0]  = maskRead;
          default:        next_pslverr      = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Captured value rides with the request, both straight from flops
  assign dmaReq.req      = chReq;
  assign dmaReq.captData = capt0;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_CNT_INC: assert property (ce && ctrl[TCCD_CTRL_RUN]
      |=> counter == 16'($past(counter) + 16'h0001))
    else $error("counter did not advance by one");
  AST_CAPT_COPY: assert property (ce && captEvt |=> capt0 == $past(counter))
    else $error("capture register missed the counter value");
  AST_CMP_TOGGLE: assert property (ce && cmpHit |=> cmpPin != $past(cmpPin))
    else $error("compare match did not toggle the pin");
  AST_NO_SPURIOUS_TOGGLE: assert property (!(ce && cmpHit) |=> $stable(cmpPin))
    else $error("compare pin moved without a match");
  AST_EVT_IRQ: assert property (ce && captEvt && !dmaSel[TCCD_CH_CAPT]
      |=> status[TCCD_EVT_CAPT])
    else $error("capture in interrupt mode left no status bit");
  AST_SEL_READ: assert property ($rose(pready) && psel && regIdx == TCCD_IDX_MASK
      |-> prdata[TCCD_MASK_CP_DMA] == $past(dmaSel[TCCD_CH_CAPT])
          && prdata[TCCD_MASK_CM_DMA] == $past(dmaSel[TCCD_CH_CMP]))
    else $error("select bits not seen at bits 6 and 3");
  AST_CAPT_DMA: assert property (ce && captEvt && dmaSel[TCCD_CH_CAPT]
      && !dmaAck.eob && !wrEn
      |=> dmaReq.req[TCCD_CH_CAPT] && status[TCCD_EVT_CAPT] == $past(status[TCCD_EVT_CAPT]))
    else $error("capture in DMA mode did not request or raised a flag");
  AST_CMP_RELOAD: assert property (ce && dmaAck.ack[TCCD_CH_CMP]
      |=> cmp0 == $past(dmaAck.wrData))
    else $error("compare register not reloaded on grant");
  AST_DMA_NO_IRQ: assert property (ce && cmpHit && dmaSel[TCCD_CH_CMP] && !wrEn
      |=> status[TCCD_EVT_CMP] == $past(status[TCCD_EVT_CMP]))
    else $error("compare in DMA mode raised a flag");
  AST_IRQ_LEVEL: assert property (ce |=> irq == |(status & irqMask))
    else $error("interrupt output disagrees with status and mask");

  // Compare events route the same way as capture events
  AST_CMP_IRQ: assert property (ce && cmpHit && !dmaSel[TCCD_CH_CMP]
      |=> status[TCCD_EVT_CMP])
    else $error("compare in interrupt mode left no status bit");
  AST_CMP_DMA: assert property (ce && cmpHit && dmaSel[TCCD_CH_CMP]
      && !dmaAck.eob && !wrEn |=> dmaReq.req[TCCD_CH_CMP])
    else $error("compare in DMA mode raised no request");
  AST_STAT_W1C: assert property (ce && wrEn && regIdx == TCCD_IDX_STAT
      && evtSet == 8'h00 |=> (status & $past(pwdata[7:0])) == 8'h00)
    else $error("status bit survived a one-to-clear write");

  // Held values move only on their own events, and never while frozen
  AST_CAPT_HOLD: assert property (!(ce && captEvt) |=> $stable(capt0))
    else $error("capture register moved without an event");
  AST_CMP0_HOLD: assert property (!(ce && (dmaAck.ack[TCCD_CH_CMP] || wrEn))
      |=> $stable(cmp0))
    else $error("compare register moved without a write or reload");
  AST_CNT_FREEZE: assert property (!ce |=> $stable(counter))
    else $error("counter moved while the clock enable was low");

  // Bus answer is a single-cycle pulse; an error only rides with it
  AST_PREADY_ONE: assert property (ce && pready |=> !pready)
    else $error("ready held for more than one cycle");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("error response without ready");

  // Main scenarios the bench must reach
  COV_CAPT_DMA_EOB: cover property (dmaReq.req[TCCD_CH_CAPT] ##[1:20]
      (dmaAck.ack[TCCD_CH_CAPT] && dmaAck.eob));
  COV_CMP_RELOAD: cover property (dmaReq.req[TCCD_CH_CMP] ##[1:20] dmaAck.ack[TCCD_CH_CMP]);
  COV_IRQ: cover property ($rose(irq));
  COV_FOREIGN_EOB: cover property (dmaAck.eob && !(|dmaAck.ack) && |dmaSel);
  COV_FALL_CAPT: cover property (ce && captEvt && ctrl[TCCD_CTRL_FALL]);

endmodule

// file: pkg/tccd_pkg.sv
// Notes on behaviour
// - Timer is a free 16-bit up-counter with capture and compare functions.
// - A qualifying capture pin edge copies the counter into capture0_value_reg.
// - Counter equal to compare0_value_reg toggles the compare output pin.
// - Each event raises either an interrupt status bit or a DMA request.
// - capture0_dma_select is mask bit 6, compare0_dma_select is mask bit 3.
// - With capture0_dma_select set, a capture requests DMA instead of interrupt.
// - With compare0_dma_select set, a compare requests DMA reload of compare register.
// - On transfer_count_done the timer clears the select bit of that block.
// - With its select bit cleared a channel issues no DMA requests.
// - In DMA mode capture stores and compare reloads need no service routine.
package tccd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] TCCD_IDX_CTRL  = 10'h000;
  localparam logic [9:0] TCCD_IDX_COUNT = 10'h001;
  localparam logic [9:0] TCCD_IDX_CAPT0 = 10'h002;
  localparam logic [9:0] TCCD_IDX_CMP0  = 10'h003;
  localparam logic [9:0] TCCD_IDX_STAT  = 10'h004;
  localparam logic [9:0] TCCD_IDX_MASK  = 10'h0ff;

  // Control register fields
  localparam int TCCD_CTRL_RUN     = 0;
  localparam int TCCD_CTRL_CAPT_EN = 1;
  localparam int TCCD_CTRL_CMP_EN  = 2;
  localparam int TCCD_CTRL_FALL    = 3;

  // Mask, status and DMA select fields
  localparam int TCCD_MASK_CP_DMA = 6;
  localparam int TCCD_MASK_CM_DMA = 3;
  localparam int TCCD_EVT_CAPT    = 4;
  localparam int TCCD_EVT_CMP     = 1;

  // Channel numbering
  localparam int TCCD_CH_CAPT = 0;
  localparam int TCCD_CH_CMP  = 1;
  localparam int TCCD_NCH     = 2;

  // Reset values
  localparam logic [7:0]  TCCD_CTRL_RST  = 8'h00;
  localparam logic [7:0]  TCCD_STAT_RST  = 8'h00;
  localparam logic [7:0]  TCCD_IRQM_RST  = 8'h00;
  localparam logic [15:0] TCCD_CNT_RST   = 16'h0000;
  localparam logic [15:0] TCCD_CAPT_RST  = 16'h0000;
  localparam logic [15:0] TCCD_CMP_RST   = 16'hffff;
  localparam logic        TCCD_PIN_RST   = 1'b0;
  localparam logic        TCCD_SEL_RST   = 1'b0;

  // Requests toward the DMA controller
  typedef struct packed {
    logic [TCCD_NCH-1:0] req;
    logic [15:0]         captData;
  } tccd_dma_req_s;

  // Grants and block end from the DMA controller
  typedef struct packed {
    logic [TCCD_NCH-1:0] ack;
    logic                eob;
    logic [15:0]         wrData;
  } tccd_dma_ack_s;

endpackage

// file: src/tccd_sync.sv
`timescale 1ns/10ps
module tccd_sync
  import tccd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  // Asynchronous level in, synchronous level out
  input  wire logic din,
  output logic      dout
);

  logic stage1;
  logic next_stage1;
  logic next_dout;

  // Plain two-stage shift, first stage feeds only the second
  always_comb begin
    next_stage1 = ce ? din : stage1;
    next_dout   = ce ? stage1 : dout;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= TCCD_PIN_RST;
      dout   <= TCCD_PIN_RST;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end

endmodule

// file: src/tccd_dma_chan.sv
`timescale 1ns/10ps
module tccd_dma_chan
  import tccd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  // Software access to the select bit
  input  wire logic swWr,
  input  wire logic swVal,
  // Timer event and controller answers
  input  wire logic evt,
  input  wire logic ack,
  input  wire logic eob,
  // Select bit and pending request
  output logic      sel,
  output logic      req
);

  logic next_sel;
  logic next_req;

  // Select bit and request; a software write beats the block-end clear
  always_comb begin
    next_sel = sel;
    next_req = req;
    if (ce) begin
      if (ack && eob) begin
        next_sel = 1'b0;
      end
      if (swWr) begin
        next_sel = swVal;
      end
      if (ack) begin
        next_req = 1'b0;
      end
      if (evt && sel) begin
        next_req = 1'b1;
      end
      if (!next_sel) begin
        next_req = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel <= TCCD_SEL_RST;
      req <= 1'b0;
    end else begin
      sel <= next_sel;
      req <= next_req;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_EOB_CLEAR: assert property (ce && ack && eob && !swWr |=> !sel && !req)
    else $error("select bit not cleared on own block end");
  AST_REQ_NEEDS_SEL: assert property (req |-> sel)
    else $error("request pending without select bit");
  AST_FOREIGN_EOB: assert property (ce && eob && !ack && !swWr |=> sel == $past(sel))
    else $error("select bit changed on a foreign block end");
  AST_EVT_REQ: assert property (ce && evt && sel && !eob && !swWr |=> req)
    else $error("event with select set raised no request");

endmodule

// file: bench/tccd_dma_model.sv
`timescale 1ns/10ps
module tccd_dma_model
  import tccd_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // Timer side
  input  wire tccd_dma_req_s dmaReq,
  output tccd_dma_ack_s      dmaAck,
  // Bench controls
  input  wire logic [3:0]    blkLen,
  input  wire logic          load,
  input  wire logic [3:0]    stall,
  input  wire logic          foreignEob,
  input  wire logic [15:0]   reloadBase,
  output logic [15:0]        lastCapt
);
  logic [3:0] cnt [2];
  logic [3:0] waitCnt;
  logic       pick;

  // Capture channel wins when both ask
  assign pick = ~dmaReq.req[0];

  // Grant after a stall; no grant while the last one is still visible
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dmaAck <= '0;
      cnt <= '{4'h0, 4'h0};
      waitCnt <= 4'h0;
      lastCapt <= 16'h0000;
    end else begin
      dmaAck.ack <= 2'b00;
      dmaAck.eob <= foreignEob;
      dmaAck.wrData <= ~dmaAck.wrData; // Data not valid outside a grant
      if (load) begin
        cnt <= '{blkLen, blkLen};
      end else if (dmaReq.req != 2'b00 && dmaAck.ack == 2'b00) begin
        if (waitCnt < stall) begin
          waitCnt <= waitCnt + 4'h1;
        end else begin
          waitCnt <= 4'h0;
          dmaAck.ack[pick] <= 1'b1;
          cnt[pick] <= cnt[pick] - 4'h1;
          dmaAck.eob <= (cnt[pick] == 4'h1) | foreignEob;
          if (!pick) begin
            lastCapt <= dmaReq.captData;
          end else begin
            dmaAck.wrData <= reloadBase + {12'h000, cnt[pick]};
          end
        end
      end
    end
  end
endmodule

// file: bench/tccd_timer_tb_top.sv
`timescale 1ns/10ps
module tccd_timer_tb_top import tccd_pkg::*;;
  logic          clk_sys = 1'b0;
  logic          rst_n = 1'b0;
  logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0, prdata, rd, c1, c2;
  logic          pready, pslverr, err, cmpPin, irq, captPin = 1'b0;
  logic          load = 1'b0, fEob = 1'b0, ce = 1'b1;
  logic [3:0]    blkLen = 4'h2, stall = 4'h0;
  logic [15:0]   lastCapt, keep;
  tccd_dma_req_s dmaReq;
  tccd_dma_ack_s dmaAck;
  integer        seed = 62683;
  int            bad_count = 0, checks = 0, i;

  // Design and its DMA controller
  tccd_timer i_tccd_timer (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .captPin(captPin),
    .cmpPin(cmpPin), .dmaReq(dmaReq), .dmaAck(dmaAck), .irq(irq));
  tccd_dma_model i_tccd_dma_model (.clk_sys(clk_sys), .rst_n(rst_n), .dmaReq(dmaReq),
    .dmaAck(dmaAck), .blkLen(blkLen), .load(load), .stall(stall), .foreignEob(fEob),
    .reloadBase(16'hf000), .lastCapt(lastCapt));

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Mask view: the two stored enables plus the two DMA selects
  function automatic logic [31:0] exp_mask(input logic [7:0] w);
    exp_mask = 32'h0;
    exp_mask[TCCD_MASK_CP_DMA] = w[TCCD_MASK_CP_DMA];
    exp_mask[TCCD_MASK_CM_DMA] = w[TCCD_MASK_CM_DMA];
    exp_mask[TCCD_EVT_CAPT]    = w[TCCD_EVT_CAPT];
    exp_mask[TCCD_EVT_CMP]     = w[TCCD_EVT_CMP];
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One APB transfer; an idle edge after it keeps drivers single per step
  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    if (n == 20) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic rdc(input string nm, input logic [9:0] ix, input logic [31:0] e);
    apb(1'b0, ix, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic pulse();
    captPin <= 1'b1;
    tick(8);
    captPin <= 1'b0;
    tick(8);
  endtask

  // Bounded wait for the interrupt or a compare pin change
  task automatic wait_ev(input logic p0);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge clk_sys);
      if (irq === 1'b1 || cmpPin !== p0) break;
    end
    if (n == 300) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic reload(input logic [3:0] len);
    keep = $random(seed);
    stall <= {2'b00, keep[1:0]};
    blkLen <= len;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask

  // Main sequence
  initial begin
    tick(10);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc("ctrl", TCCD_IDX_CTRL, 32'h0);
    rdc("cmp0", TCCD_IDX_CMP0, 32'h0000ffff);
    rdc("stat", TCCD_IDX_STAT, 32'h0);
    rdc("mask", TCCD_IDX_MASK, 32'h0);
    rdc("hole", 10'h3a0, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    for (i = 0; i < 6; i++) begin
      keep = $random(seed);
      apb(1'b1, TCCD_IDX_MASK, {24'h0, keep[7:0]});
      rdc("mask_rb", TCCD_IDX_MASK, exp_mask(keep[7:0]));
    end
    // Two-word capture block; compare select must survive its end
    reload(4'h2);
    apb(1'b1, TCCD_IDX_MASK, 32'h48);
    apb(1'b1, TCCD_IDX_CTRL, 32'h3);
    pulse();
    rdc("capt_dma", TCCD_IDX_CAPT0, {16'h0, lastCapt});
    rdc("mask_mid", TCCD_IDX_MASK, 32'h48);
    pulse();
    rdc("mask_eob", TCCD_IDX_MASK, 32'h08);
    rdc("stat_dma", TCCD_IDX_STAT, 32'h0);
    keep = lastCapt;
    pulse();
    chk("no_dma", {16'h0, keep}, {16'h0, lastCapt});
    chk("irq_off", 32'h0, {31'h0, irq});
    rdc("stat_cap", TCCD_IDX_STAT, 32'h10);
    apb(1'b1, TCCD_IDX_MASK, 32'h10);
    tick(3);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, TCCD_IDX_STAT, 32'h10);
    tick(3);
    chk("irq_clr", 32'h0, {31'h0, irq});
    // Captured value lies between two counter reads
    apb(1'b0, TCCD_IDX_COUNT, 32'h0);
    c1 = rd;
    captPin <= 1'b1;
    wait_ev(cmpPin);
    apb(1'b0, TCCD_IDX_CAPT0, 32'h0);
    keep = rd[15:0];
    apb(1'b0, TCCD_IDX_COUNT, 32'h0);
    c2 = rd;
    chk("capt_win", 32'h1, {31'h0, keep > c1[15:0] && keep < c2[15:0]});
    captPin <= 1'b0;
    apb(1'b1, TCCD_IDX_STAT, 32'h10);
    // Block end of someone else leaves the selects alone
    apb(1'b1, TCCD_IDX_MASK, 32'h48);
    fEob <= 1'b1;
    @(posedge clk_sys);
    fEob <= 1'b0;
    rdc("mask_foreign", TCCD_IDX_MASK, 32'h48);
    // Clock enable low for 20 cycles: two reads stay four counts apart
    apb(1'b0, TCCD_IDX_COUNT, 32'h0);
    c1 = rd;
    ce <= 1'b0;
    tick(20);
    ce <= 1'b1;
    apb(1'b0, TCCD_IDX_COUNT, 32'h0);
    chk("freeze", 32'h4, rd - c1);
    // Compare match in interrupt mode
    apb(1'b1, TCCD_IDX_MASK, 32'h02);
    apb(1'b0, TCCD_IDX_COUNT, 32'h0);
    apb(1'b1, TCCD_IDX_CMP0, {16'h0, rd[15:0] + 16'h0028});
    apb(1'b1, TCCD_IDX_CTRL, 32'h7);
    wait_ev(cmpPin);
    tick(3);
    chk("cmp_pin", 32'h1, {31'h0, cmpPin});
    chk("cmp_irq", 32'h1, {31'h0, irq});
    apb(1'b1, TCCD_IDX_STAT, 32'h02);
    // Compare match in DMA mode reloads the compare value
    reload(4'h1);
    apb(1'b1, TCCD_IDX_MASK, 32'h08);
    apb(1'b0, TCCD_IDX_COUNT, 32'h0);
    apb(1'b1, TCCD_IDX_CMP0, {16'h0, rd[15:0] + 16'h0028});
    wait_ev(1'b1);
    tick(8);
    rdc("cmp_reload", TCCD_IDX_CMP0, 32'h0000f001);
    rdc("mask_cm_eob", TCCD_IDX_MASK, 32'h0);
    rdc("stat_cm", TCCD_IDX_STAT, 32'h0);
    // Falling-edge capture ignores the rising edge of the pin
    apb(1'b1, TCCD_IDX_CTRL, 32'hb);
    apb(1'b1, TCCD_IDX_MASK, 32'h0);
    captPin <= 1'b1;
    tick(8);
    rdc("stat_rise", TCCD_IDX_STAT, 32'h0);
    captPin <= 1'b0;
    tick(8);
    rdc("stat_fall", TCCD_IDX_STAT, 32'h10);
    // Reset in mid-run brings back the reset values
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc("cmp0_rst", TCCD_IDX_CMP0, 32'h0000ffff);
    rdc("stat_rst", TCCD_IDX_STAT, 32'h0);
    tally_and_finish();
  end
endmodule
